// ==== logic/tmds_pkg.sv ====
// Shared constants of the tandem monitor defect sink.
package tmds_pkg;
   // Multiframe layout, frame numbers counted from 1.
   localparam logic [11:0] TMDS_FAS_WORD   = 12'hFFE;
   localparam logic [6:0]  TMDS_MF_LEN     = 7'h4C;
   localparam logic [6:0]  TMDS_FAS_END    = 7'h06;
   localparam logic [6:0]  TMDS_TTI_FIRST  = 7'h09;
   localparam logic [6:0]  TMDS_TTI_LAST   = 7'h48;
   localparam logic [6:0]  TMDS_RDI_FRM    = 7'h49;
   localparam logic [6:0]  TMDS_ODI_FRM    = 7'h4A;
   // Persistence counts.
   localparam logic [2:0]  TMDS_UNEQ_CNT   = 3'h5;
   localparam logic [1:0]  TMDS_TIM_CNT    = 2'h3;
   // Register byte offsets.
   localparam logic [7:0]  TMDS_REG_CTRL   = 8'h00;
   localparam logic [7:0]  TMDS_REG_THR    = 8'h04;
   localparam logic [7:0]  TMDS_REG_DEGM   = 8'h08;
   localparam logic [7:0]  TMDS_REG_STAT   = 8'h0C;
   localparam logic [7:0]  TMDS_REG_NCNT   = 8'h10;
   localparam logic [7:0]  TMDS_REG_FCNT   = 8'h14;
   localparam logic [7:0]  TMDS_REG_OCNT   = 8'h18;
   localparam logic [7:0]  TMDS_REG_DSEC   = 8'h1C;
   localparam logic [7:0]  TMDS_REG_TRACE  = 8'h20;
   // Control bit positions and values after reset.
   localparam int          TMDS_CTL_SUP    = 0;
   localparam int          TMDS_CTL_TOFF   = 1;
   localparam int          TMDS_CTL_RSSF   = 2;
   localparam int          TMDS_CTL_RRDI   = 3;
   localparam int          TMDS_CTL_RODI   = 4;
   localparam logic [4:0]  TMDS_CTRL_RST   = 5'h01;
   localparam logic [15:0] TMDS_THR_RST    = 16'h0001;
   localparam logic [3:0]  TMDS_DEGM_RST   = 4'h3;
endpackage

// ==== logic/tmds_mfa.sv ====
// Multiframe aligner on the two low bits of the tandem overhead byte.
`timescale 1ns/10ps
module tmds_mfa
   import tmds_pkg::*;
(
   input  wire logic       i_clk,
   input  wire logic       i_nrst,
   input  wire logic       i_stb,
   input  wire logic [1:0] i_bits,
   output logic            o_locked,
   output logic            o_stb,
   output logic [6:0]      o_idx,
   output logic [1:0]      o_bits
);
   logic [11:0] sr_r;
   logic [11:0] sr_nxt;
   logic [6:0]  idx_r;
   logic [6:0]  idx_nxt;
   logic        locked_r;
   logic        err_r;
   logic        stb_r;
   logic [1:0]  bits_r;

   assign sr_nxt  = {sr_r[9:0], i_bits};
   assign idx_nxt = (idx_r == TMDS_MF_LEN) ? 7'h01 : idx_r + 7'h01;

   always_ff @(posedge i_clk)
   begin
      if (!i_nrst)
      begin
         sr_r     <= 12'h000;
         idx_r    <= 7'h00;
         locked_r <= 1'b0;
         err_r    <= 1'b0;
         stb_r    <= 1'b0;
         bits_r   <= 2'h0;
      end
      else
      begin
         stb_r <= i_stb;
         if (i_stb)
         begin
            sr_r   <= sr_nxt;
            bits_r <= i_bits;
            if (!locked_r)
            begin
               if (sr_nxt == TMDS_FAS_WORD)
               begin
                  locked_r <= 1'b1;
                  idx_r    <= TMDS_FAS_END;
                  err_r    <= 1'b0;
               end
            end
            else
            begin
               idx_r <= idx_nxt;
               if (idx_nxt == TMDS_FAS_END)
               begin
                  if (sr_nxt != TMDS_FAS_WORD)
                  begin
                     if (err_r)
                        locked_r <= 1'b0;
                     err_r <= 1'b1;
                  end
                  else
                     err_r <= 1'b0;
               end
            end
         end
      end
   end

   assign o_locked = locked_r;
   assign o_stb    = stb_r;
   assign o_idx    = idx_r;
   assign o_bits   = bits_r;

   sequence s_bad_word;
      i_stb && locked_r && idx_nxt == TMDS_FAS_END && sr_nxt != TMDS_FAS_WORD;
   endsequence

   a_lost_twice: assert property (@(posedge i_clk) disable iff (!i_nrst)
      (s_bad_word and err_r) |=> !locked_r)
      else $error("aligner kept lock after two errored words");
   a_lock_found: assert property (@(posedge i_clk) disable iff (!i_nrst)
      (i_stb && !locked_r && sr_nxt == TMDS_FAS_WORD) |=> locked_r && o_idx == TMDS_FAS_END)
      else $error("aligner missed a clean alignment word");
endmodule

// ==== logic/tmds_pm.sv ====
// One-second performance counts and degrade evaluation.
`timescale 1ns/10ps
module tmds_pm
   import tmds_pkg::*;
#(
   parameter int CNT_W = 16
)
(
   input  wire logic             i_clk,
   input  wire logic             i_nrst,
   input  wire logic             i_tick,
   input  wire logic             i_trail_fail,
   input  wire logic             i_equip_fault,
   input  wire logic             i_remote,
   input  wire logic             i_outgoing,
   input  wire logic             i_near_blk,
   input  wire logic             i_far_blk,
   input  wire logic             i_out_blk,
   input  wire logic [CNT_W-1:0] i_thr,
   input  wire logic [3:0]       i_deg_m,
   output logic [CNT_W-1:0]      o_near_cnt,
   output logic [CNT_W-1:0]      o_far_cnt,
   output logic [CNT_W-1:0]      o_out_cnt,
   output logic [2:0]            o_dsec,
   output logic                  o_degrade
);
   function automatic logic [CNT_W-1:0] bump(input logic [CNT_W-1:0] v, input logic e);
      return (e && v != '1) ? v + {{(CNT_W-1){1'b0}}, 1'b1} : v;
   endfunction

   logic [CNT_W-1:0] nacc_r;
   logic [CNT_W-1:0] facc_r;
   logic [CNT_W-1:0] oacc_r;
   logic [2:0]       ds_r;
   logic [2:0]       ds_nxt;
   logic [3:0]       bad_r;
   logic [3:0]       good_r;
   logic             bad_sec;

   assign ds_nxt  = ds_r | {i_outgoing, i_remote, i_trail_fail | i_equip_fault};
   assign bad_sec = bump(nacc_r, i_near_blk) >= i_thr;

   always_ff @(posedge i_clk)
   begin
      if (!i_nrst)
      begin
         nacc_r     <= '0;
         facc_r     <= '0;
         oacc_r     <= '0;
         ds_r       <= 3'h0;
         o_near_cnt <= '0;
         o_far_cnt  <= '0;
         o_out_cnt  <= '0;
         o_dsec     <= 3'h0;
      end
      else if (i_tick)
      begin
         o_near_cnt <= bump(nacc_r, i_near_blk);
         o_far_cnt  <= bump(facc_r, i_far_blk);
         o_out_cnt  <= bump(oacc_r, i_out_blk);
         o_dsec     <= ds_nxt;
         nacc_r     <= '0;
         facc_r     <= '0;
         oacc_r     <= '0;
         ds_r       <= 3'h0;
      end
      else
      begin
         nacc_r <= bump(nacc_r, i_near_blk);
         facc_r <= bump(facc_r, i_far_blk);
         oacc_r <= bump(oacc_r, i_out_blk);
         ds_r   <= ds_nxt;
      end
   end

   // Degrade sets after m bad seconds in a row and clears after m good ones.
   always_ff @(posedge i_clk)
   begin
      if (!i_nrst)
      begin
         bad_r     <= 4'h0;
         good_r    <= 4'h0;
         o_degrade <= 1'b0;
      end
      else if (i_tick)
      begin
         if (bad_sec)
         begin
            good_r <= 4'h0;
            bad_r  <= (bad_r == 4'hF) ? bad_r : bad_r + 4'h1;
            if ({1'b0, bad_r} + 5'h01 >= {1'b0, i_deg_m})
               o_degrade <= 1'b1;
         end
         else
         begin
            bad_r  <= 4'h0;
            good_r <= (good_r == 4'hF) ? good_r : good_r + 4'h1;
            if ({1'b0, good_r} + 5'h01 >= {1'b0, i_deg_m})
               o_degrade <= 1'b0;
         end
      end
   end

   a_deg_set: assert property (@(posedge i_clk) disable iff (!i_nrst)
      (i_tick && bad_sec && {1'b0, bad_r} + 5'h01 >= {1'b0, i_deg_m}) |=> o_degrade)
      else $error("degrade not raised after enough bad seconds");
   a_near_dsec: assert property (@(posedge i_clk) disable iff (!i_nrst)
      (i_tick && (i_trail_fail || i_equip_fault)) |=> o_dsec[0])
      else $error("near defect second missed");
endmodule

// ==== logic/tmds_sink.sv ====
// Tandem monitor defect sink: link sampling, defects, causes and registers.
//
// The address map and strobed register access were decided locally.
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
// Functional notes
// - Unequipped defect sets after five frames in a row with a zero overhead byte.
// - Unequipped defect clears after five frames in a row with a non-zero byte.
// - Lost-tandem defect follows the aligner: on when lost, off when locked.
// - Trace mismatch rises and clears within one second without bit errors.
// - Trace mismatch is held off while incoming server fail is present.
// - A control bit switches trace mismatch detection off.
// - Degrade comes from parity block errors and drives trail degrade directly.
// - Remote defect follows the remote bit of the multiframe.
// - Outgoing defect follows the outgoing bit of the multiframe.
// - Trail fail is server fail, unequipped, mismatch or lost-tandem.
// - Unequipped cause direct; lost-tandem cause only without unequipped.
// - Mismatch cause only without unequipped and lost-tandem.
// - Degrade cause only without mismatch and lost-tandem.
// - Server fail cause needs its report option, which resets off.
// - Remote cause needs option and no unequipped, mismatch, lost-tandem.
// - Outgoing cause needs option and no unequipped, mismatch, lost-tandem.
// - Per second: defect seconds and errored block sums.
// - Aligner searches the alignment word and keeps checking it.
// - Two errored alignment words in a row lose the multiframe.
// - One clean alignment word regains the multiframe.
// - Near block error when parity count differs from carried count.
////////////////////////////////////////////////////////////////////////////////
module tmds_sink
   import tmds_pkg::*;
#(
   parameter logic [11:0] NR_POS = 12'h003,
   parameter logic [11:0] EM_POS = 12'h002,
   parameter int          CNT_W  = 16
)
(
   input  wire logic        i_clk,
   input  wire logic        i_nrst,
   input  wire logic        i_link_clk,
   input  wire logic        i_link_fs,
   input  wire logic [7:0]  i_link_data,
   input  wire logic        i_server_fail,
   input  wire logic        i_equip_fault,
   input  wire logic        i_tick_1s,
   input  wire logic [7:0]  i_addr,
   input  wire logic [31:0] i_wdata,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   output logic [31:0]      o_rdata,
   output logic             o_trail_fail_out,
   output logic             o_trail_degrade_out,
   output logic             o_unequipped_cause,
   output logic             o_lost_tandem_cause,
   output logic             o_trace_mismatch_cause,
   output logic             o_degrade_cause,
   output logic             o_server_fail_cause,
   output logic             o_remote_defect_cause,
   output logic             o_outgoing_defect_cause
);
   function automatic logic [3:0] ones(input logic [7:0] v);
      logic [3:0] n;
      n = 4'h0;
      for (int i = 0; i < 8; i++)
         n = n + {3'h0, v[i]};
      return n;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Link sampling: clock, frame start, server fail and data pass three stages.
   logic [10:0] s1_r;
   logic [10:0] s2_r;
   logic [10:0] s3_r;
   logic        lclk_r;
   logic        ssf_r;
   logic        stb;
   logic        fs;
   logic [7:0]  lbyte;

   always_ff @(posedge i_clk)
   begin
      if (!i_nrst)
      begin
         s1_r   <= 11'h000;
         s2_r   <= 11'h000;
         s3_r   <= 11'h000;
         lclk_r <= 1'b0;
         ssf_r  <= 1'b0;
      end
      else
      begin
         s1_r <= {i_link_clk, i_link_fs, i_server_fail, i_link_data};
         s2_r <= s1_r;
         s3_r <= s2_r;
         if (s2_r[10] == s3_r[10])
            lclk_r <= s3_r[10];
         if (s2_r[8] == s3_r[8])
            ssf_r <= s3_r[8];
      end
   end

   assign stb   = s2_r[10] && s3_r[10] && !lclk_r;
   assign fs    = s3_r[9];
   assign lbyte = s3_r[7:0];

   ////////////////////////////////////////////////////////////////////////////
   // Frame position, parity and overhead byte extraction.
   logic [11:0] pos_r;
   logic [11:0] cur_pos;
   logic [7:0]  par_r;
   logic [7:0]  prev_par_r;
   logic [3:0]  em_err_r;
   logic        is_nr;
   logic        near_blk;

   assign cur_pos  = fs ? 12'h000 : pos_r;
   assign is_nr    = stb && cur_pos == NR_POS;
   assign near_blk = is_nr && em_err_r != lbyte[7:4];

   always_ff @(posedge i_clk)
   begin
      if (!i_nrst)
      begin
         pos_r      <= 12'h000;
         par_r      <= 8'h00;
         prev_par_r <= 8'h00;
         em_err_r   <= 4'h0;
      end
      else if (stb)
      begin
         pos_r <= cur_pos + 12'h001;
         if (fs)
         begin
            prev_par_r <= par_r;
            par_r      <= lbyte;
         end
         else
            par_r <= par_r ^ lbyte;
         if (cur_pos == EM_POS)
            em_err_r <= ones(prev_par_r ^ lbyte);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Unequipped detection.
   logic [2:0] zero_cnt_r;
   logic [2:0] nz_cnt_r;
   logic       uneq_r;

   always_ff @(posedge i_clk)
   begin
      if (!i_nrst)
      begin
         zero_cnt_r <= 3'h0;
         nz_cnt_r   <= 3'h0;
         uneq_r     <= 1'b0;
      end
      else if (is_nr)
      begin
         if (lbyte == 8'h00)
         begin
            nz_cnt_r <= 3'h0;
            if (zero_cnt_r != TMDS_UNEQ_CNT)
               zero_cnt_r <= zero_cnt_r + 3'h1;
            if (zero_cnt_r + 3'h1 >= TMDS_UNEQ_CNT)
               uneq_r <= 1'b1;
         end
         else
         begin
            zero_cnt_r <= 3'h0;
            if (nz_cnt_r != TMDS_UNEQ_CNT)
               nz_cnt_r <= nz_cnt_r + 3'h1;
            if (nz_cnt_r + 3'h1 >= TMDS_UNEQ_CNT)
               uneq_r <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Multiframe content: trace, remote and outgoing bits.
   logic         locked;
   logic         mf_stb;
   logic [6:0]   mf_idx;
   logic [1:0]   mf_bits;
   logic         mf_end;
   logic [127:0] trace_r;
   logic [31:0]  exp_r [4];
   logic         rdi_pend_r;
   logic         odi_pend_r;
   logic         remote_r;
   logic         outgoing_r;
   logic         tim_raw_r;
   logic [1:0]   tim_cnt_r;
   logic         tim_def;
   logic         mism;
   logic [4:0]   ctrl_r;

   tmds_mfa u_mfa (
      .i_clk    (i_clk),
      .i_nrst   (i_nrst),
      .i_stb    (is_nr),
      .i_bits   (lbyte[1:0]),
      .o_locked (locked),
      .o_stb    (mf_stb),
      .o_idx    (mf_idx),
      .o_bits   (mf_bits)
   );

   assign mf_end  = mf_stb && locked && mf_idx == TMDS_MF_LEN;
   assign mism    = trace_r != {exp_r[0], exp_r[1], exp_r[2], exp_r[3]};
   assign tim_def = tim_raw_r && !ssf_r && !ctrl_r[TMDS_CTL_TOFF];

   always_ff @(posedge i_clk)
   begin
      if (!i_nrst)
      begin
         trace_r    <= '0;
         rdi_pend_r <= 1'b0;
         odi_pend_r <= 1'b0;
         remote_r   <= 1'b0;
         outgoing_r <= 1'b0;
         tim_raw_r  <= 1'b0;
         tim_cnt_r  <= 2'h0;
      end
      else if (mf_stb)
      begin
         if (mf_idx >= TMDS_TTI_FIRST && mf_idx <= TMDS_TTI_LAST)
            trace_r <= {trace_r[125:0], mf_bits};
         if (mf_idx == TMDS_RDI_FRM)
            rdi_pend_r <= mf_bits[0];
         if (mf_idx == TMDS_ODI_FRM)
            odi_pend_r <= mf_bits[1];
         if (mf_end)
         begin
            remote_r   <= rdi_pend_r;
            outgoing_r <= odi_pend_r;
            if (mism != tim_raw_r)
            begin
               tim_cnt_r <= tim_cnt_r + 2'h1;
               if (tim_cnt_r + 2'h1 == TMDS_TIM_CNT)
               begin
                  tim_raw_r <= mism;
                  tim_cnt_r <= 2'h0;
               end
            end
            else
               tim_cnt_r <= 2'h0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Consequent actions, correlations and performance.
   logic             ltc;
   logic             tsf;
   logic             deg;
   logic             sup;
   logic [15:0]      thr_r;
   logic [3:0]       degm_r;
   logic [CNT_W-1:0] ncnt;
   logic [CNT_W-1:0] fcnt;
   logic [CNT_W-1:0] ocnt;
   logic [2:0]       dsec;

   assign ltc = !locked;
   assign tsf = ssf_r || uneq_r || tim_def || ltc;
   assign sup = ctrl_r[TMDS_CTL_SUP];

   tmds_pm #(.CNT_W(CNT_W)) u_pm (
      .i_clk         (i_clk),
      .i_nrst        (i_nrst),
      .i_tick        (i_tick_1s),
      .i_trail_fail  (tsf),
      .i_equip_fault (i_equip_fault),
      .i_remote      (remote_r),
      .i_outgoing    (outgoing_r),
      .i_near_blk    (near_blk),
      .i_far_blk     (is_nr && lbyte[3]),
      .i_out_blk     (is_nr && lbyte[2]),
      .i_thr         (CNT_W'(thr_r)),
      .i_deg_m       (degm_r),
      .o_near_cnt    (ncnt),
      .o_far_cnt     (fcnt),
      .o_out_cnt     (ocnt),
      .o_dsec        (dsec),
      .o_degrade     (deg)
   );

   always_ff @(posedge i_clk)
   begin
      if (!i_nrst)
      begin
         o_trail_fail_out        <= 1'b0;
         o_trail_degrade_out     <= 1'b0;
         o_unequipped_cause      <= 1'b0;
         o_lost_tandem_cause     <= 1'b0;
         o_trace_mismatch_cause  <= 1'b0;
         o_degrade_cause         <= 1'b0;
         o_server_fail_cause     <= 1'b0;
         o_remote_defect_cause   <= 1'b0;
         o_outgoing_defect_cause <= 1'b0;
      end
      else
      begin
         o_trail_fail_out        <= tsf;
         o_trail_degrade_out     <= deg;
         // Every cause is gated by supervision.
         o_unequipped_cause      <= sup && uneq_r;
         o_lost_tandem_cause     <= sup && !uneq_r && ltc;
         o_trace_mismatch_cause  <= sup && !uneq_r && !ltc && tim_def;
         o_degrade_cause         <= sup && !tim_def && !ltc && deg;
         o_server_fail_cause     <= sup && ssf_r && ctrl_r[TMDS_CTL_RSSF];
         o_remote_defect_cause   <= sup && !uneq_r && !tim_def && !ltc && remote_r
                                    && ctrl_r[TMDS_CTL_RRDI];
         o_outgoing_defect_cause <= sup && !uneq_r && !tim_def && !ltc && outgoing_r
                                    && ctrl_r[TMDS_CTL_RODI];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register port.
   always_ff @(posedge i_clk)
   begin
      if (!i_nrst)
      begin
         ctrl_r <= TMDS_CTRL_RST;
         thr_r  <= TMDS_THR_RST;
         degm_r <= TMDS_DEGM_RST;
         exp_r  <= '{default: 32'h0000_0000};
      end
      else if (i_wr)
      begin
         if (i_addr == TMDS_REG_CTRL)
            ctrl_r <= i_wdata[4:0];
         if (i_addr == TMDS_REG_THR)
            thr_r <= i_wdata[15:0];
         if (i_addr == TMDS_REG_DEGM)
            degm_r <= i_wdata[3:0];
         if (i_addr[7:4] == TMDS_REG_TRACE[7:4] && i_addr[1:0] == 2'h0)
            exp_r[i_addr[3:2]] <= i_wdata;
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (!i_nrst || !i_rd)
         o_rdata <= 32'h0000_0000;
      else if (i_addr[7:4] == TMDS_REG_TRACE[7:4] && i_addr[1:0] == 2'h0)
         o_rdata <= exp_r[i_addr[3:2]];
      else
      begin
         unique case (i_addr)
            TMDS_REG_CTRL: o_rdata <= {27'h0, ctrl_r};
            TMDS_REG_THR:  o_rdata <= {16'h0, thr_r};
            TMDS_REG_DEGM: o_rdata <= {28'h0, degm_r};
            TMDS_REG_STAT: o_rdata <= {25'h0, ssf_r, outgoing_r, remote_r, deg,
                                       tim_def, ltc, uneq_r};
            TMDS_REG_NCNT: o_rdata <= 32'(ncnt);
            TMDS_REG_FCNT: o_rdata <= 32'(fcnt);
            TMDS_REG_OCNT: o_rdata <= 32'(ocnt);
            TMDS_REG_DSEC: o_rdata <= {29'h0, dsec};
            default:       o_rdata <= 32'h0000_0000;
         endcase
      end
   end

   a_uneq_set: assert property (@(posedge i_clk) disable iff (!i_nrst)
      (is_nr && lbyte == 8'h00 && zero_cnt_r == 3'h4) |=> uneq_r)
      else $error("unequipped not set on fifth zero byte");
   a_uneq_clr: assert property (@(posedge i_clk) disable iff (!i_nrst)
      (is_nr && lbyte != 8'h00 && nz_cnt_r == 3'h4) |=> !uneq_r)
      else $error("unequipped not cleared on fifth non-zero byte");
   a_tsf_map: assert property (@(posedge i_clk) disable iff (!i_nrst)
      (i_nrst && !locked) |=> o_trail_fail_out)
      else $error("trail fail low while multiframe lost");
   a_tim_ssf: assert property (@(posedge i_clk) disable iff (!i_nrst)
      ssf_r |=> !o_trace_mismatch_cause)
      else $error("mismatch cause during server fail");
   a_tim_off: assert property (@(posedge i_clk) disable iff (!i_nrst)
      ctrl_r[TMDS_CTL_TOFF] |=> !o_trace_mismatch_cause)
      else $error("mismatch cause while detection off");
   a_tsd_follow: assert property (@(posedge i_clk) disable iff (!i_nrst)
      ##1 o_trail_degrade_out == $past(deg))
      else $error("trail degrade does not follow degrade");
   a_ltc_mask: assert property (@(posedge i_clk) disable iff (!i_nrst)
      (uneq_r || !sup) |=> !o_lost_tandem_cause)
      else $error("lost tandem cause not masked");
   a_sup_off: assert property (@(posedge i_clk) disable iff (!i_nrst)
      !sup |=> !(o_unequipped_cause || o_lost_tandem_cause || o_trace_mismatch_cause
                 || o_degrade_cause || o_server_fail_cause || o_remote_defect_cause
                 || o_outgoing_defect_cause))
      else $error("cause reported without supervision");
   a_remote_hold: assert property (@(posedge i_clk) disable iff (!i_nrst)
      !mf_end |=> $stable(remote_r) && $stable(outgoing_r))
      else $error("remote state changed off a locked boundary");
endmodule

// ==== test/tmds_src.sv ====
// Upstream tandem source model: framed link bytes on its own byte clock.
`timescale 1ns/10ps
module tmds_src
#(
   parameter int FLEN = 8
)
(
   output logic       o_clk,
   output logic       o_fs,
   output logic [7:0] o_data,
   input  wire logic  i_uneq,
   input  wire logic  i_rdi,
   input  wire logic  i_odi
);
   logic [7:0] par, em, nr;
   int         b, f;
   initial
   begin
      {o_clk, o_fs, o_data, par, em, b, f} = '0;
      forever
      begin
         #100 o_clk = 1'b0;
         nr = (f < 5) ? 8'h03 : (f == 5) ? 8'h02 : (f == 72) ? {7'h00, i_rdi}
            : (f == 73) ? {6'h00, i_odi, 1'b1} : 8'h01;
         o_fs = (b == 0);
         o_data = (b == 2) ? em : (b == 3) ? (i_uneq ? 8'h00 : nr) : 8'hA5 ^ 8'(b);
         par = par ^ o_data;
         #100 o_clk = 1'b1;
         b = (b + 1) % FLEN;
         if (b == 0)
         begin
            em = par;
            par = 8'h00;
            f = (f + 1) % 76;
         end
      end
   end
endmodule

// ==== test/tb.sv ====
// Self-checking bench for the tandem monitor defect sink.
`timescale 1ns/10ps
module tb
   import tmds_pkg::*;
;
   logic        clk = 0, nrst = 0, sf = 0, tick = 0, wr = 0, rd = 0, rd_d = 0;
   logic        uneq = 0, rdi = 0, odi = 0, eq = 0, lclk, lfs;
   logic [7:0]  addr = 0, ldat;
   logic [31:0] wdata = 0, rdata, w;
   logic [31:0] expq[$];
   wire  [8:0]  o;
   int          err_count = 0, checks_done = 0, cyc = 0, seed = 55, i;
   always #12.5 clk = ~clk;
   tmds_src src (.o_clk(lclk), .o_fs(lfs), .o_data(ldat), .i_uneq(uneq), .i_rdi(rdi),
      .i_odi(odi));
   tmds_sink uut (.i_clk(clk), .i_nrst(nrst), .i_link_clk(lclk), .i_link_fs(lfs),
      .i_link_data(ldat), .i_server_fail(sf), .i_equip_fault(eq), .i_tick_1s(tick),
      .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
      .o_trail_fail_out(o[0]), .o_trail_degrade_out(o[1]), .o_unequipped_cause(o[2]),
      .o_lost_tandem_cause(o[3]), .o_trace_mismatch_cause(o[4]), .o_degrade_cause(o[5]),
      .o_server_fail_cause(o[6]), .o_remote_defect_cause(o[7]),
      .o_outgoing_defect_cause(o[8]));
   task automatic final_report();
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic cmp(string n, logic [31:0] e, logic [31:0] s);
      checks_done++;
      if (s !== e)
      begin
         err_count++;
         $display("wrong value %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic wreg(logic [7:0] a, logic [31:0] d);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rreg(logic [7:0] a, logic [31:0] e);
      expq.push_back(e);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(posedge clk);
   endtask
   task automatic wlvl(int n, logic e, int lim);
      for (int k = 0; k < lim && o[n] !== e; k++)
         @(posedge clk);
      cmp($sformatf("output %0d", n), {31'h0, e}, {31'h0, o[n]});
   endtask
   task automatic pulse();
      tick <= 1'b1;
      @(posedge clk);
      tick <= 1'b0;
      @(posedge clk);
   endtask
   // Read data are judged in the cycle after the strobe; the cycle ceiling cuts a hang.
   always @(posedge clk)
   begin
      rd_d <= rd;
      cyc <= cyc + 1;
      if (rd_d)
         cmp("read data", expq.pop_front(), rdata);
      if (cyc == 90000)
      begin
         err_count++;
         final_report();
      end
   end
   initial
   begin
      repeat (5) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      wlvl(0, 1'b1, 4);
      wlvl(3, 1'b1, 4);
      rreg(TMDS_REG_CTRL, 32'h1);
      rreg(8'hFC, 32'h0);
      w = $random(seed) | 1;
      wreg(TMDS_REG_THR, w);
      rreg(TMDS_REG_THR, {16'h0, w[15:0]});
      for (i = 0; i < 4; i++)
         wreg(TMDS_REG_TRACE + 8'(4 * i), 32'h55555555);
      wlvl(3, 1'b0, 12000);
      wlvl(0, 1'b0, 30000);
      rreg(TMDS_REG_STAT, 32'h0);
      $display("test alignment done");
      wreg(TMDS_REG_THR, 32'h0);
      repeat (2) pulse();
      eq <= 1'b1;
      pulse();
      eq <= 1'b0;
      wlvl(1, 1'b1, 4);
      wlvl(5, 1'b1, 2);
      rreg(TMDS_REG_STAT, 32'h8);
      rreg(TMDS_REG_DSEC, 32'h1);
      rreg(TMDS_REG_NCNT, 32'h0);
      wreg(TMDS_REG_THR, w);
      repeat (3) pulse();
      wlvl(1, 1'b0, 4);
      $display("test degrade done");
      wreg(TMDS_REG_CTRL, 32'h19);
      {rdi, odi} <= 2'b11;
      wlvl(7, 1'b1, 12000);
      wlvl(8, 1'b1, 1);
      rreg(TMDS_REG_STAT, 32'h30);
      wreg(TMDS_REG_CTRL, 32'h18);
      wlvl(7, 1'b0, 4);
      wlvl(8, 1'b0, 1);
      wreg(TMDS_REG_CTRL, 32'h19);
      wlvl(7, 1'b1, 4);
      {rdi, odi} <= 2'b00;
      wlvl(7, 1'b0, 12000);
      wlvl(8, 1'b0, 1);
      $display("test remote done");
      wreg(TMDS_REG_CTRL, 32'h05);
      sf <= 1'b1;
      wlvl(6, 1'b1, 12);
      wlvl(0, 1'b1, 2);
      sf <= 1'b0;
      wlvl(6, 1'b0, 12);
      wreg(TMDS_REG_TRACE, 32'h55555554);
      wlvl(4, 1'b1, 20000);
      wlvl(0, 1'b1, 1);
      rreg(TMDS_REG_STAT, 32'h4);
      wreg(TMDS_REG_CTRL, 32'h03);
      wlvl(4, 1'b0, 4);
      wreg(TMDS_REG_CTRL, 32'h01);
      wlvl(4, 1'b1, 4);
      sf <= 1'b1;
      wlvl(4, 1'b0, 12);
      sf <= 1'b0;
      wlvl(4, 1'b1, 12);
      wreg(TMDS_REG_TRACE, 32'h55555555);
      wlvl(4, 1'b0, 20000);
      $display("test trace done");
      pulse();
      uneq <= 1'b1;
      wlvl(2, 1'b1, 1000);
      repeat (12000) @(posedge clk);
      wlvl(3, 1'b0, 1);
      rreg(TMDS_REG_STAT, 32'h3);
      pulse();
      rreg(TMDS_REG_DSEC, 32'h1);
      uneq <= 1'b0;
      wlvl(2, 1'b0, 1000);
      wlvl(0, 1'b0, 30000);
      $display("test unequipped done");
      final_report();
   end
endmodule
